// ==== verilog/grrb_pkg.sv ====
// package: opcodes, sizes and timing constants for the gpio read return buffer
`default_nettype none
package grrb_pkg;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SET_UPPER   = 8'h82;
  localparam logic [7:0] OP_READ_UPPER  = 8'h83;
  localparam logic [7:0] OP_SEND_IMMED  = 8'h87;
  // ----------------------------------------
  // buffer and timing
  // ----------------------------------------
  localparam int FRAME_BYTES   = 510;
  localparam int BUF_DEPTH     = 512;
  localparam int LATENCY_MS    = 16;
  localparam int CLK_MHZ       = 250;
  localparam int LATENCY_CYC   = LATENCY_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] UPPER_DIR_RST = 8'h00;
  localparam logic [7:0] UPPER_VAL_RST = 8'h00;
  // ----------------------------------------
  // command decoder states
  // ----------------------------------------
  typedef enum logic [1:0] {
    GRRB_IDLE = 2'b00,
    GRRB_VAL  = 2'b01,
    GRRB_DIR  = 2'b11
  } grrb_state_t;
endpackage
`default_nettype wire

// ==== verilog/grrb_top.sv ====
// module: command interpreter, upper port pins and return buffer with release logic
`timescale 1ns/100ps
`default_nettype none
module grrb_top #(
  parameter int DEPTH       = grrb_pkg::BUF_DEPTH,
  parameter int FRAME       = grrb_pkg::FRAME_BYTES,
  parameter int LATENCY_CNT = grrb_pkg::LATENCY_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // command byte stream from the usb out side
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  // usb in side: host-requested packet bytes
  input  wire logic       in_request,
  output logic [7:0]      in_data,
  output logic            in_valid,
  output logic            in_last,
  // upper gpio port bits 7..0
  input  wire logic [7:0] upper_gpio_port_in,
  output logic [7:0]      upper_gpio_port_out,
  output logic [7:0]      upper_gpio_port_oe
);
  // ----------------------------------------
  // derived sizes
  // ----------------------------------------
  localparam int            AW       = $clog2(DEPTH);
  localparam int            CW       = AW + 1;
  localparam int            TW       = $clog2(LATENCY_CNT) + 1;
  localparam logic [CW-1:0] DEPTH_W  = CW'(DEPTH);
  localparam logic [CW-1:0] FRAME_W  = CW'(FRAME);
  localparam logic [TW-1:0] LAT_LAST = TW'(LATENCY_CNT - 1);

  // pointers wrap by power of two; a frame larger than the store could never release
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || FRAME < 1 || FRAME > DEPTH || LATENCY_CNT < 2)
  begin : g_bad_params
    $error("grrb_top: unsupported parameters");
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  always_ff @(posedge clk_sys)
  begin
    pin_s1_reg <= upper_gpio_port_in;
    pin_s2_reg <= pin_s1_reg;
  end

  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  grrb_pkg::grrb_state_t state_reg;
  grrb_pkg::grrb_state_t state_next;
  logic [7:0]            buf_mem [DEPTH];
  logic [AW-1:0]         wr_ptr_reg;
  logic [AW-1:0]         rd_ptr_reg;
  logic [CW-1:0]         count_reg;
  logic [CW-1:0]         avail_reg;
  logic [TW-1:0]         timer_reg;
  logic [7:0]            val_hold_reg;
  logic [7:0]            upper_out_reg;
  logic [7:0]            upper_oe_reg;
  logic                  cmd_ready_reg;
  logic [7:0]            in_data_reg;
  logic                  in_valid_reg;
  logic                  in_last_reg;

  // ----------------------------------------
  // decode and release wires
  // ----------------------------------------
  logic          cmd_take;
  logic          in_idle;
  logic          op_set;
  logic          op_read;
  logic          op_send;
  logic          take_val;
  logic          take_dir;
  logic          push;
  logic          pop;
  logic          unreleased;
  logic          timer_hit;
  logic          frame_full;
  logic          release_now;
  logic [CW-1:0] push_w;
  logic [CW-1:0] pop_w;
  logic [CW-1:0] count_next;
  logic [CW-1:0] avail_next;
  logic [TW-1:0] timer_next;
  logic [AW-1:0] wr_ptr_next;
  logic [AW-1:0] rd_ptr_next;
  logic          cmd_ready_next;
  logic          in_last_next;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign cmd_take = cmd_valid && cmd_ready_reg;
  assign in_idle  = (state_reg == grrb_pkg::GRRB_IDLE);
  assign op_set   = cmd_take && in_idle && (cmd_data == grrb_pkg::OP_SET_UPPER);
  assign op_read  = cmd_take && in_idle && (cmd_data == grrb_pkg::OP_READ_UPPER);
  assign op_send  = cmd_take && in_idle && (cmd_data == grrb_pkg::OP_SEND_IMMED);
  assign take_val = cmd_take && (state_reg == grrb_pkg::GRRB_VAL);
  assign take_dir = cmd_take && (state_reg == grrb_pkg::GRRB_DIR);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      grrb_pkg::GRRB_IDLE:
      begin
        if (op_set)
          state_next = grrb_pkg::GRRB_VAL;
      end
      grrb_pkg::GRRB_VAL:
      begin
        if (take_val)
          state_next = grrb_pkg::GRRB_DIR;
      end
      grrb_pkg::GRRB_DIR:
      begin
        if (take_dir)
          state_next = grrb_pkg::GRRB_IDLE;
      end
      default:
        state_next = grrb_pkg::GRRB_IDLE;
    endcase
  end

  // ----------------------------------------
  // return buffer bookkeeping
  // ----------------------------------------
  // cmd_ready is dropped before the store overflows, so a read never needs a free check
  assign push           = op_read;
  assign pop            = in_request && (avail_reg != '0);
  assign push_w         = CW'(push);
  assign pop_w          = CW'(pop);
  assign count_next     = count_reg + push_w - pop_w;
  assign wr_ptr_next    = wr_ptr_reg + AW'(push);
  assign rd_ptr_next    = rd_ptr_reg + AW'(pop);
  // bytes beyond avail are held back until one of the release events
  assign unreleased     = (count_reg != avail_reg);
  assign timer_hit      = unreleased && (timer_reg == LAT_LAST);
  assign frame_full     = (count_next >= FRAME_W);
  assign release_now    = op_send || timer_hit || frame_full;
  assign avail_next     = release_now ? count_next : (avail_reg - pop_w);
  assign timer_next     = (release_now || !unreleased) ? '0 : (timer_reg + TW'(1));
  assign cmd_ready_next = (count_next != DEPTH_W);
  assign in_last_next   = pop && (avail_next == '0);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_reg <= grrb_pkg::GRRB_IDLE;
    else
      state_reg <= state_next;
  end

  // storage has no reset; only released entries are ever read
  always_ff @(posedge clk_sys)
  begin
    if (push)
      buf_mem[wr_ptr_reg] <= pin_s2_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      avail_reg  <= '0;
      timer_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      avail_reg  <= avail_next;
      timer_reg  <= timer_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmd_ready_reg <= 1'b0;
      in_valid_reg  <= 1'b0;
      in_last_reg   <= 1'b0;
      in_data_reg   <= 8'h00;
    end
    else
    begin
      cmd_ready_reg <= cmd_ready_next;
      in_valid_reg  <= pop;
      in_last_reg   <= in_last_next;
      if (pop)
        in_data_reg <= buf_mem[rd_ptr_reg];
    end
  end

  // value byte waits until the direction byte so both reach the pins together
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      val_hold_reg  <= grrb_pkg::UPPER_VAL_RST;
      upper_out_reg <= grrb_pkg::UPPER_VAL_RST;
      upper_oe_reg  <= grrb_pkg::UPPER_DIR_RST;
    end
    else
    begin
      if (take_val)
        val_hold_reg <= cmd_data;
      if (take_dir)
      begin
        upper_out_reg <= val_hold_reg;
        upper_oe_reg  <= cmd_data;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_ready           = cmd_ready_reg;
  assign in_data             = in_data_reg;
  assign in_valid            = in_valid_reg;
  assign in_last             = in_last_reg;
  assign upper_gpio_port_out = upper_out_reg;
  assign upper_gpio_port_oe  = upper_oe_reg;
endmodule
`default_nettype wire

// ==== verification/grrb_monitor.sv ====
// checker: port relations of the return buffer
`timescale 1ns/100ps
`default_nettype none
module grrb_monitor (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // command side
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  // usb in side
  input wire logic       in_request,
  input wire logic [7:0] in_data,
  input wire logic       in_valid,
  input wire logic       in_last,
  // upper port
  input wire logic [7:0] upper_gpio_port_in,
  input wire logic [7:0] upper_gpio_port_out,
  input wire logic [7:0] upper_gpio_port_oe
);
  a_last_in_packet: assert property (@(posedge clk_sys) disable iff (!rst_n) in_last |-> in_valid)
    else $error("last without valid");
  a_dir_holds: assert property (@(posedge clk_sys) disable iff (!rst_n) !cmd_valid [*3] |-> $stable(upper_gpio_port_oe))
    else $error("direction moved");
  a_only_requested: assert property (@(posedge clk_sys) disable iff (!rst_n) in_valid |-> $past(in_request))
    else $error("data unrequested");
  a_reset_quiet: assert property (@(posedge clk_sys) !rst_n |=> !in_valid && !cmd_ready)
    else $error("outputs active after reset");
  a_out_by_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(upper_gpio_port_out) |-> $past(cmd_valid && cmd_ready))
    else $error("pin value moved without command");
  a_oe_from_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(upper_gpio_port_oe) |-> $past(cmd_valid && cmd_ready) && upper_gpio_port_oe == $past(cmd_data))
    else $error("direction not from command byte");
  a_data_with_valid: assert property (@(posedge clk_sys) disable iff (!rst_n) $changed(in_data) |-> in_valid)
    else $error("in data moved without valid");
endmodule
`default_nettype wire

// ==== verification/grrb_host.sv ====
// host model: asks for in packets once out of reset
`timescale 1ns/100ps
`default_nettype none
module grrb_host (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // usb in request
  output var logic  in_request
);
  // host polls for in packets continuously once out of reset
  always_ff @(posedge clk_sys)
  begin
    in_request <= rst_n;
  end
endmodule
`default_nettype wire

// ==== verification/grrb_tb.sv ====
// testbench: pin write, pin read, send-immediate, timer and full-frame release
`timescale 1ns/100ps
`default_nettype none
module tb;
  // short timer so the expiry path fits in the run
  localparam int LAT_T = 3000;
  logic       clk_sys    = 1'b0;
  logic       rst_n      = 1'b0;
  logic       cmd_valid  = 1'b0;
  logic [7:0] cmd_data   = 8'h00;
  logic [7:0] pins       = 8'h00;
  logic       cmd_ready;
  logic       in_request;
  logic       in_valid;
  logic       in_last;
  logic [7:0] in_data;
  logic [7:0] out;
  logic [7:0] oe;
  logic [7:0] v;
  logic [7:0] d;
  logic       last_seen  = 1'b0;
  int         err_count  = 0;
  int         num_checks = 0;
  int         seed       = 67;
  int         n;
  int         got        = 0;
  logic [7:0] exp_q[$];

  grrb_top #(
    .LATENCY_CNT (LAT_T)
  ) i_grrb_top (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .cmd_data            (cmd_data),
    .cmd_valid           (cmd_valid),
    .cmd_ready           (cmd_ready),
    .in_request          (in_request),
    .in_data             (in_data),
    .in_valid            (in_valid),
    .in_last             (in_last),
    .upper_gpio_port_in  (pins),
    .upper_gpio_port_out (out),
    .upper_gpio_port_oe  (oe)
  );
  grrb_host i_grrb_host (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .in_request (in_request)
  );

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", what, e, g);
      err_count++;
    end
  endtask

  // valid drops for one edge between bytes so no signal is driven twice in a step
  task automatic put(input logic [7:0] b);
    cmd_data  <= b;
    cmd_valid <= 1'b1;
    n = 0;
    do
      @(posedge clk_sys);
    while (!cmd_ready && ++n < 99);
    cmd_valid <= 1'b0;
    if (n >= 99)
    begin
      $display("unexpected cmd_ready exp 1 got 0");
      err_count++;
    end
    @(posedge clk_sys);
  endtask

  task automatic wait_got(input int target, input int limit);
    n = 0;
    while (got < target && n < limit)
    begin
      @(posedge clk_sys);
      n++;
    end
    num_checks++;
    if (got < target)
    begin
      $display("unexpected bytes_returned exp %0d got %0d", target, got);
      err_count++;
    end
  endtask

  // model: every returned byte must be the oldest pin sample still owed
  always @(posedge clk_sys)
  begin
    if (rst_n && in_valid)
    begin
      got       <= got + 1;
      last_seen <= in_last;
      if (exp_q.size() > 0)
        chk("in_data", exp_q.pop_front(), in_data);
      else
      begin
        num_checks++;
        err_count++;
        $display("unexpected in_data exp none got %h", in_data);
      end
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int t = 0; t < 4; t++)
    begin
      {v, d} = 16'($random(seed));
      pins <= 8'($random(seed));
      put(grrb_pkg::OP_SET_UPPER);
      put(v);
      put(d);
      @(posedge clk_sys);
      chk("oe", d, oe);
      chk("out", v, out);
      exp_q.push_back(pins);
      put(grrb_pkg::OP_READ_UPPER);
      put(grrb_pkg::OP_SEND_IMMED);
      wait_got(t + 1, 99);
      chk("in_last", 8'h01, {7'h00, last_seen});
      $display("test %0d done", t);
    end
    pins <= 8'($random(seed));
    repeat (2) @(posedge clk_sys);
    exp_q.push_back(pins);
    put(grrb_pkg::OP_READ_UPPER);
    wait_got(5, LAT_T + 100);
    num_checks++;
    if (n < LAT_T - 8 || n > LAT_T + 8)
    begin
      $display("unexpected timer_release exp %0d got %0d", LAT_T, n);
      err_count++;
    end
    $display("test 4 done");
    for (int i = 0; i < grrb_pkg::FRAME_BYTES; i++)
    begin
      pins <= 8'($random(seed));
      repeat (2) @(posedge clk_sys);
      exp_q.push_back(pins);
      if (i == grrb_pkg::FRAME_BYTES - 1)
        chk("early_bytes", 8'h05, 8'(got));
      put(grrb_pkg::OP_READ_UPPER);
    end
    wait_got(5 + grrb_pkg::FRAME_BYTES, 1000);
    chk("frame_last", 8'h01, {7'h00, last_seen});
    $display("test 5 done");
    print_verdict;
  end
endmodule
bind grrb_top grrb_monitor i_grrb_monitor (
  .clk_sys             (clk_sys),
  .rst_n               (rst_n),
  .cmd_data            (cmd_data),
  .cmd_valid           (cmd_valid),
  .cmd_ready           (cmd_ready),
  .in_request          (in_request),
  .in_data             (in_data),
  .in_valid            (in_valid),
  .in_last             (in_last),
  .upper_gpio_port_in  (upper_gpio_port_in),
  .upper_gpio_port_out (upper_gpio_port_out),
  .upper_gpio_port_oe  (upper_gpio_port_oe)
);
`default_nettype wire
